// ---- design/nvc_ctrl.sv ----
`timescale 1ns/100ps
`include "nvc_defines.svh"
// Functional notes
// R1: Setting go bit launches cycle; clear ignored
// R2: Hardware clears go bit when cycle ends
// R3: Erase or write only with permit set
// R4: Permit bit cleared at every completion
// R5: Pin/watchdog reset mid-cycle sets abort flag
// R6: Skip bit set: write programs directly
// R7: Skip bit clear: write erases first
// R8: Erase bit picks erase versus write
// R9: Codes 011010/011001/011000 erase 8/4/1
// R10: Code 0100xx erases whole array
// R11: Write code 0010xx programs one word
// R12: Low code bits set partial erase size
// R13: Address is 8-bit upper, 16-bit lower
// R14: Latches capture last table-write address
// R15: Address latches not on register bus
// R16: Lower latch bit zero forced to zero
// R17: Upper latch top bit forced to zero
// R18: Array is 16 bits, low word only
// R19: Software must not read during cycle
// R20: Software orders setup, key, then go
// R21: Done flag set at end of cycle
// R22: Software erases first when skipping
// R23: Bulk erase ignores address latches
// R24: Go needs key just before and permit
module nvc_ctrl
  import nvc_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Table-write capture from the CPU
  input wire logic tblwt_valid,
  input wire logic [23:0] tblwt_addr,
  input wire logic [15:0] tblwt_data,
  // Abort-causing reset events
  input wire logic ext_pin_reset,
  input wire logic watchdog_reset,
  // Array command port
  output logic mem_req,
  output logic mem_erase,
  output logic mem_bulk,
  output logic [3:0] mem_words,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  // Status
  output logic busy,
  output logic done_irq_flag
);

  // ========================================================================
  // Declarations
  logic go_r;
  logic program_permit_r;
  logic aborted_op_flag_r;
  logic skip_preerase_r;
  logic erase_sel_r;
  logic [5:0] op_code_field_r;
  logic [7:0] addr_upper_latch_r;
  logic [15:0] addr_lower_latch_r;
  logic [15:0] data_latch_r;
  logic done_r;
  nvc_state_e state_r;
  nvc_state_e state_nxt;
  nvc_key_e key_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic setup_ph;
  logic acc_wr;
  logic hit_ctrl;
  logic hit_key;
  logic hit_stat;
  logic mapped;
  logic [15:0] ctrl_view;
  logic code_part;
  logic code_bulk;
  logic code_write;
  logic code_ok;
  logic start;
  logic abort_ev;
  logic finish;
  logic [3:0] part_words;

  // ========================================================================
  // APB decode
  assign setup_ph = psel & ~penable;
  assign acc_wr = psel & penable & pwrite & ce;
  assign hit_ctrl = (paddr == `NVC_OFF_CONTROL);
  assign hit_key = (paddr == `NVC_OFF_KEY);
  assign hit_stat = (paddr == `NVC_OFF_STATUS);
  assign mapped = hit_ctrl | hit_key | hit_stat;

  // Read data is sampled in setup, so access completes in one cycle while ce is high; ce low holds pready low
  assign pready = psel & penable & ce;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r & pready;

  // Control register as software sees it; unused bits read zero
  // The go bit reads one for the whole cycle, which polling relies on
  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[`NVC_GO_BIT] = go_r;
    ctrl_view[`NVC_PERMIT_BIT] = program_permit_r;
    ctrl_view[`NVC_ABORT_BIT] = aborted_op_flag_r;
    ctrl_view[`NVC_SKIP_BIT] = skip_preerase_r;
    ctrl_view[`NVC_ERASE_BIT] = erase_sel_r;
    ctrl_view[`NVC_OP_MSB:`NVC_OP_LSB] = op_code_field_r;
  end

  // Read mux registered at setup; the key register reads back zero and the
  // address latches have no address at all [R15]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (ce && setup_ph) begin
      pslverr_r <= ~mapped;
      if (hit_ctrl) begin
        prdata_r <= {16'h0000, ctrl_view};
      end else if (hit_stat) begin
        prdata_r <= {31'h00000000, done_r};
      end else begin
        prdata_r <= 32'h00000000;
      end
    end
  end

  // ========================================================================
  // Operation code decode
  // Partial erase sizes come from the two low code bits [R12]
  always_comb begin
    part_words = `NVC_WORDS_1;
    unique case (op_code_field_r[1:0])
      2'b10: part_words = `NVC_WORDS_8; // [R9]
      2'b01: part_words = `NVC_WORDS_4; // [R9]
      default: part_words = `NVC_WORDS_1; // [R9]
    endcase
  end

  assign code_part = (op_code_field_r == `NVC_OP_ERASE8) |
                     (op_code_field_r == `NVC_OP_ERASE4) |
                     (op_code_field_r == `NVC_OP_ERASE1); // [R9]
  assign code_bulk = (op_code_field_r[5:2] == `NVC_OP_BULK_TOP); // [R10]
  assign code_write = (op_code_field_r[5:2] == `NVC_OP_WRITE_TOP); // [R11]
  // Erase bit chooses which code table applies [R8]
  assign code_ok = erase_sel_r ? (code_part | code_bulk) : code_write;

  // Go is honoured only straight after the key and with permit set;
  // an unknown code is dropped rather than guessing at a size
  assign start = acc_wr & hit_ctrl & pwdata[`NVC_GO_BIT] &
                 (key_r == NVC_KEY_ARMED) & program_permit_r &
                 (state_r == NVC_IDLE) & code_ok; // [R1] [R3] [R24]

  assign abort_ev = (ext_pin_reset | watchdog_reset) &
                    (state_r != NVC_IDLE) & ce; // [R5]
  assign finish = ce & mem_ack & ~abort_ev &
                  ((state_r == NVC_PROG) |
                   ((state_r == NVC_ERASE) & erase_sel_r));
  assign busy = (state_r != NVC_IDLE);

  // ========================================================================
  // Unlock key tracker: any other bus write breaks the sequence
  // Reads leave it alone, so polling between key writes is harmless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_r <= NVC_KEY_NONE;
    end else if (acc_wr) begin
      if (hit_key && pwdata[7:0] == `NVC_KEY_FIRST) begin
        key_r <= NVC_KEY_HALF;
      end else if (hit_key && pwdata[7:0] == `NVC_KEY_SECOND &&
                   key_r == NVC_KEY_HALF) begin
        key_r <= NVC_KEY_ARMED;
      end else begin
        key_r <= NVC_KEY_NONE; // [R24]
      end
    end
  end

  // ========================================================================
  // Configuration fields; frozen while a cycle runs so the array sees a
  // stable command. The go write that launches a cycle leaves them alone
  // too: the command was fixed before the key, and a go write with other
  // bits must not change the size half-way through the cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_preerase_r <= 1'b0;
      erase_sel_r <= 1'b0;
      op_code_field_r <= 6'h00;
    end else if (acc_wr && hit_ctrl && state_r == NVC_IDLE &&
                 !start) begin
      skip_preerase_r <= pwdata[`NVC_SKIP_BIT];
      erase_sel_r <= pwdata[`NVC_ERASE_BIT];
      op_code_field_r <= pwdata[`NVC_OP_MSB:`NVC_OP_LSB];
    end
  end

  // Go bit: software sets only, hardware clears at the end or on abort
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_r <= 1'b0;
    end else if (start) begin
      go_r <= 1'b1; // [R1]
    end else if (finish || abort_ev) begin
      go_r <= 1'b0; // [R2]
    end
  end

  // Permit bit: writable when idle, dropped by hardware after each cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_permit_r <= 1'b0;
    end else if (finish || abort_ev) begin
      program_permit_r <= 1'b0; // [R4]
    end else if (acc_wr && hit_ctrl && state_r == NVC_IDLE) begin
      program_permit_r <= pwdata[`NVC_PERMIT_BIT]; // [R3]
    end
  end

  // Abort flag: hardware set wins over a software write in the same cycle
  // Abort leaves done low, so software can tell a cut cycle from a clean one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aborted_op_flag_r <= 1'b0;
    end else if (abort_ev) begin
      aborted_op_flag_r <= 1'b1; // [R5]
    end else if (finish) begin
      aborted_op_flag_r <= 1'b0; // [R5]
    end else if (acc_wr && hit_ctrl) begin
      aborted_op_flag_r <= pwdata[`NVC_ABORT_BIT];
    end
  end

  // Done flag: write one to clear, a completion in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else if (finish) begin
      done_r <= 1'b1; // [R21]
    end else if (acc_wr && hit_stat && pwdata[`NVC_DONE_BIT]) begin
      done_r <= 1'b0;
    end
  end
  assign done_irq_flag = done_r;

  // ========================================================================
  // Table-write capture; latches held during a cycle so the target cannot
  // move under the array
  // The lowest bit is dropped, not refused: each location holds one word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_upper_latch_r <= `NVC_ADDR_UPPER_RST;
      addr_lower_latch_r <= `NVC_ADDR_LOWER_RST;
      data_latch_r <= `NVC_DATA_RST;
    end else if (ce && tblwt_valid && state_r == NVC_IDLE) begin
      addr_upper_latch_r <= {1'b0, tblwt_addr[22:16]}; // [R13] [R14] [R17]
      addr_lower_latch_r <= {tblwt_addr[15:1], 1'b0}; // [R13] [R14] [R16]
      data_latch_r <= tblwt_data; // [R18]
    end
  end

  // ========================================================================
  // Sequencer. The array's ack is only seen while ce is high; an array
  // that acks during a frozen cycle must hold the ack until ce returns,
  // or the cycle waits for an ack that never comes
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      NVC_IDLE: begin
        if (start) begin
          // A write without skip erases its word first [R6] [R7]
          if (erase_sel_r || !skip_preerase_r) begin
            state_nxt = NVC_ERASE;
          end else begin
            state_nxt = NVC_PROG; // [R6]
          end
        end
      end
      NVC_ERASE: begin
        if (abort_ev) begin
          state_nxt = NVC_IDLE;
        end else if (mem_ack) begin
          state_nxt = erase_sel_r ? NVC_IDLE : NVC_PROG; // [R7]
        end
      end
      NVC_PROG: begin
        if (abort_ev || mem_ack) begin
          state_nxt = NVC_IDLE;
        end
      end
      default: state_nxt = NVC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= NVC_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // ========================================================================
  // Array command outputs, registered from the next state so a command
  // appears in the same cycle as the state machine enters its phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req <= 1'b0;
      mem_erase <= 1'b0;
      mem_bulk <= 1'b0;
      mem_words <= 4'h0;
      mem_addr <= `NVC_ADDR_RST;
      mem_wdata <= `NVC_DATA_RST;
    end else if (ce) begin
      mem_req <= (state_nxt != NVC_IDLE);
      mem_erase <= (state_nxt == NVC_ERASE);
      // Bulk erase covers the array whatever the latches hold [R23]
      mem_bulk <= (state_nxt == NVC_ERASE) & erase_sel_r & code_bulk;
      if (state_nxt == NVC_ERASE && erase_sel_r && code_part) begin
        mem_words <= part_words; // [R12]
      end else if (state_nxt != NVC_IDLE) begin
        mem_words <= `NVC_WORDS_1;
      end else begin
        mem_words <= 4'h0;
      end
      mem_addr <= {addr_upper_latch_r, addr_lower_latch_r}; // [R14]
      mem_wdata <= data_latch_r;
    end
  end

endmodule : nvc_ctrl

// ---- design/nvc_defines.svh ----
`ifndef NVC_DEFINES_SVH
`define NVC_DEFINES_SVH
// ==========================================================================
// Register offsets (byte addresses on APB)
`define NVC_OFF_CONTROL 12'h000
`define NVC_OFF_KEY 12'h004
`define NVC_OFF_STATUS 12'h008
// ==========================================================================
// Control register field positions; the done bit sits in the status register
`define NVC_GO_BIT 15
`define NVC_PERMIT_BIT 14
`define NVC_ABORT_BIT 13
`define NVC_SKIP_BIT 12
`define NVC_ERASE_BIT 6
`define NVC_OP_MSB 5
`define NVC_OP_LSB 0
`define NVC_DONE_BIT 0
// ==========================================================================
// Reset values
`define NVC_CONTROL_RST 16'h0000
`define NVC_ADDR_RST 24'h000000
`define NVC_ADDR_UPPER_RST 8'h00
`define NVC_ADDR_LOWER_RST 16'h0000
`define NVC_DATA_RST 16'h0000
// ==========================================================================
// Unlock key values, written in this order
`define NVC_KEY_FIRST 8'h55
`define NVC_KEY_SECOND 8'hAA
// ==========================================================================
// Operation codes
`define NVC_OP_ERASE8 6'h1A
`define NVC_OP_ERASE4 6'h19
`define NVC_OP_ERASE1 6'h18
`define NVC_OP_BULK_TOP 4'h4
`define NVC_OP_WRITE_TOP 4'h2
// ==========================================================================
// Word counts handed to the array
`define NVC_WORDS_1 4'h1
`define NVC_WORDS_4 4'h4
`define NVC_WORDS_8 4'h8
`endif

// ---- design/nvc_pkg.sv ----
// ==========================================================================
// Types shared by the program/erase controller
package nvc_pkg;
  // Sequencer states
  typedef enum logic [1:0] {
    NVC_IDLE = 2'b00,
    NVC_ERASE = 2'b01,
    NVC_PROG = 2'b10
  } nvc_state_e;

  // Unlock key tracker states
  typedef enum logic [1:0] {
    NVC_KEY_NONE = 2'b00,
    NVC_KEY_HALF = 2'b01,
    NVC_KEY_ARMED = 2'b10
  } nvc_key_e;
endpackage : nvc_pkg

// ---- design/placeholder_unused.sv ----
`timescale 1ns/100ps

// ---- tb/data_eeprom_program_erase_control_test.sv ----
`timescale 1ns/100ps
`include "nvc_defines.svh"
// ==========================================
// Register-level bench for the program/erase controller
module data_eeprom_program_erase_control_test;
  localparam logic [11:0] CTL = `NVC_OFF_CONTROL;
  localparam logic [11:0] STA = `NVC_OFF_STATUS;
  localparam logic [23:0] ADR = 24'h7FFFFE;
  localparam logic [15:0] DAT = 16'hA5C3;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic tblwt_valid = 0, ext_pin_reset = 0, watchdog_reset = 0, mem_ack = 0;
  logic pready, pslverr, mem_req, mem_erase, mem_bulk, busy, done_irq_flag;
  logic err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [23:0] tblwt_addr = 0, mem_addr;
  logic [15:0] tblwt_data = 0, mem_wdata;
  logic [3:0] mem_words;
  logic [45:0] log_q[$];
  logic [5:0] codes[5] = '{6'h1A, 6'h19, 6'h18, 6'h10, 6'h13};
  logic [3:0] wds[3] = '{4'h8, 4'h4, 4'h1};
  int miscompares = 0, tests_run = 0, cyc = 0, ack_cnt = 0, ack_dly = 2;

  always #2 pclk = ~pclk;
  nvc_ctrl dut (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .tblwt_valid(tblwt_valid), .tblwt_addr(tblwt_addr),
    .tblwt_data(tblwt_data),
    .ext_pin_reset(ext_pin_reset), .watchdog_reset(watchdog_reset),
    .mem_req(mem_req), .mem_erase(mem_erase), .mem_bulk(mem_bulk),
    .mem_words(mem_words), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack),
    .busy(busy), .done_irq_flag(done_irq_flag)
  );

  // ==========================================
  // Array stand-in: acks ack_dly+1 cycles after each command starts, logs each command
  always @(posedge pclk) begin
    mem_ack <= 0;
    ack_cnt <= 0;
    if (mem_req && !mem_ack) begin
      ack_cnt <= ack_cnt + 1;
      if (ack_cnt == ack_dly) begin
        mem_ack <= 1;
        log_q.push_back({mem_erase, mem_bulk, mem_words, mem_addr, mem_wdata});
      end
    end
  end

  // Hang guard, sized well above the longest run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  // ==========================================
  // Tasks
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic cmp(input string n, input logic [45:0] e,
                     input logic [45:0] s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : cmp

  // Setup, key pair, then go, as software must order them
  task automatic start(input logic [15:0] c);
    apb(1, CTL, c);
    apb(1, `NVC_OFF_KEY, `NVC_KEY_FIRST);
    apb(1, `NVC_OFF_KEY, `NVC_KEY_SECOND);
    apb(1, CTL, c | 16'h8000);
  endtask : start

  // Poll busy, then no reads of the array until it ends
  task automatic finish_op;
    @(posedge pclk);
    while (busy !== 0) @(posedge pclk);
    apb(0, CTL, 0);
  endtask : finish_op

  task automatic run(input logic [15:0] c);
    start(c);
    finish_op();
  endtask : run

  task automatic hit(input int w);
    @(posedge pclk);
    ext_pin_reset <= (w == 0);
    watchdog_reset <= (w == 1);
    @(posedge pclk);
    ext_pin_reset <= 0;
    watchdog_reset <= 0;
  endtask : hit

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // ==========================================
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, CTL, 0);
    cmp("control reset", `NVC_CONTROL_RST, rd);
    apb(0, 12'h00C, 0);
    cmp("unmapped error", 1, err);
    @(posedge pclk);
    tblwt_valid <= 1;
    tblwt_addr <= 24'hFFFFFF;
    tblwt_data <= DAT;
    @(posedge pclk);
    tblwt_valid <= 0;
    foreach (codes[i]) begin
      log_q.delete();
      run(16'h4040 | codes[i]);
      cmp("control after erase", 16'h0040 | codes[i], rd);
      cmp("erase count", 1, log_q.size());
      if (i < 3)
        cmp("part erase", {2'b10, wds[i], ADR}, log_q[0][45:16]);
      else
        cmp("bulk erase", 2'b11, log_q[0][45:44]);
      cmp("done pin", 1, done_irq_flag);
      apb(0, STA, 0);
      cmp("done set", 1, rd);
      apb(1, STA, 1);
    end
    log_q.delete();
    run(16'h5008);
    cmp("program only", 1, log_q.size());
    cmp("program cmd", {6'h01, ADR, DAT}, log_q[0]);
    log_q.delete();
    run(16'h400B);
    cmp("erase first", {6'h21, ADR}, log_q[0][45:16]);
    cmp("then program", {6'h01, ADR, DAT}, log_q[1]);
    log_q.delete();
    run(16'h0008);
    cmp("no permit", 0, log_q.size());
    apb(1, CTL, 16'h4008);
    apb(1, CTL, 16'hC008);
    apb(0, CTL, 0);
    cmp("go without key", 16'h4008, rd);
    cmp("no key no op", 0, log_q.size());
    // A table write while the clock enable is low must not land
    @(posedge pclk);
    ce <= 0;
    tblwt_valid <= 1;
    tblwt_addr <= 24'h000010;
    @(posedge pclk);
    ce <= 1;
    tblwt_valid <= 0;
    log_q.delete();
    run(16'h400B);
    cmp("frozen latch", {6'h01, ADR, DAT}, log_q[1]);
    apb(1, STA, 1);
    ack_dly = 40;
    for (int k = 0; k < 2; k++) begin
      start(16'h4058);
      apb(1, CTL, 16'h4058);
      apb(0, CTL, 0);
      cmp("go not cleared", 1, rd[15]);
      cmp("busy in cycle", 1, busy);
      hit(k);
      finish_op();
      cmp("aborted", 16'h2058, rd);
      apb(0, STA, 0);
      cmp("no done", 0, rd);
      cmp("no done pin", 0, done_irq_flag);
    end
    ack_dly = 2;
    // Abort flag set by software first, so only the completion clears it
    run(16'h6058);
    cmp("abort cleared", 16'h0058, rd);
    finish_test();
  end
endmodule : data_eeprom_program_erase_control_test

// ---- tb/nvc_ctrl_sva.sv ----
`timescale 1ns/100ps
// ==========================================
// Port-level checks for the program/erase controller
module nvc_ctrl_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Inputs seen
  input wire logic ext_pin_reset,
  input wire logic watchdog_reset,
  input wire logic mem_ack,
  input wire logic ce,
  // Outputs watched
  input wire logic mem_req,
  input wire logic mem_erase,
  input wire logic mem_bulk,
  input wire logic [3:0] mem_words,
  input wire logic [23:0] mem_addr,
  input wire logic busy,
  input wire logic done_irq_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Commands only carry legal addresses and sizes
  chk_addr_even: assert property (mem_req |-> !mem_addr[0])
    else $error("odd array address");
  chk_addr_top: assert property (mem_req |-> !mem_addr[23])
    else $error("array address top bit set");
  chk_bulk_erase: assert property (mem_req && mem_bulk |-> mem_erase)
    else $error("bulk command is not an erase");
  chk_part_size: assert property
    (mem_req && mem_erase && !mem_bulk |-> mem_words inside {1, 4, 8})
    else $error("bad partial erase size");
  chk_write_one: assert property
    (mem_req && !mem_erase |-> mem_words == 4'h1 && !mem_bulk)
    else $error("write is not one word");
  // Address must not move while the array works on it
  chk_addr_hold: assert property (
    mem_req && !mem_ack && !ext_pin_reset && !watchdog_reset |=>
    mem_req && $stable(mem_addr))
    else $error("command dropped or changed before ack");
  chk_abort_idle: assert property (
    busy && ce && (ext_pin_reset || watchdog_reset) |=> !busy && !mem_req)
    else $error("abort did not stop the cycle");
  chk_done_end: assert property (
    $fell(busy) && !$past(ext_pin_reset) && !$past(watchdog_reset) |->
    done_irq_flag)
    else $error("cycle ended without done");
  // Done only marks a cycle that really finished
  chk_done_cause: assert property (
    $rose(done_irq_flag) |->
    $past(busy) && !$past(ext_pin_reset) && !$past(watchdog_reset))
    else $error("done without completed cycle");
endmodule : nvc_ctrl_sva

bind nvc_ctrl nvc_ctrl_sva u_sva (
  .pclk(pclk),
  .presetn(presetn),
  .ext_pin_reset(ext_pin_reset),
  .watchdog_reset(watchdog_reset),
  .mem_ack(mem_ack),
  .ce(ce),
  .mem_req(mem_req),
  .mem_erase(mem_erase),
  .mem_bulk(mem_bulk),
  .mem_words(mem_words),
  .mem_addr(mem_addr),
  .busy(busy),
  .done_irq_flag(done_irq_flag)
);
